// >>> src/bpm_power_mode.sv
// module: battery power-mode state machine and switch control
`timescale 1ns/10ps
module bpm_power_mode #(
	parameter longint unsigned ACTIVE_TICKS  = bpm_pkg::ACTIVE_TICK_CYC,
	parameter longint unsigned STANDBY_TICKS = bpm_pkg::STANDBY_TICK_CYC,
	parameter longint unsigned SHIP_TICKS    = bpm_pkg::SHIP_TICK_CYC,
	parameter longint unsigned IDLE_TICKS    = bpm_pkg::IDLE_CYC
) (
	// clock, reset, enable
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	// firmware direction and host command
	input  wire logic                 fw_standby_en,
	input  wire logic                 ship_cmd,
	input  wire logic                 ship_cmd_auth,
	// bus line pins
	input  wire logic                 smb_clk_pin,
	input  wire logic                 smb_dat_pin,
	// measurements
	input  wire logic                 load_active,
	input  wire logic [15:0]          min_cell_mv,
	input  wire logic [15:0]          uv_threshold_mv,
	input  wire logic                 charger_present,
	// protection requests from safety logic
	input  wire bpm_pkg::bpm_switch_t safety_switch,
	// outputs
	output bpm_pkg::bpm_state_t       power_state,
	output bpm_pkg::bpm_switch_t      switch_out,
	output bpm_pkg::bpm_status_t      status_out
);
	import bpm_pkg::*;

	logic [1:0]  smb_sync;
	logic        smb_active;
	logic [15:0] uv_thresh;
	logic        uv_enter;
	logic        uv_recover;
	logic [47:0] tick_cnt;
	logic [47:0] tick_limit;
	logic [47:0] idle_cnt;
	logic        idle_done;
	logic        tick;
	bpm_state_t  next_state;
	logic        ship_logged;

	// ------------------------------------------------------------
	// bus line synchroniser
	// ------------------------------------------------------------
	bpm_pin_sync #(
		.WIDTH (2)
	) u_smb_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.pin_in   ({smb_clk_pin, smb_dat_pin}),
		.pin_sync (smb_sync)
	);

	// lines idle low in ship; either high counts as active
	assign smb_active = |smb_sync;

	// ------------------------------------------------------------
	// threshold clamp and compare
	// ------------------------------------------------------------
	function automatic logic [15:0] clamp_mv(input logic [15:0] v);
		if (v < UV_MIN_MV) begin
			return UV_MIN_MV;
		end else if (v > UV_MAX_MV) begin
			return UV_MAX_MV;
		end
		return v;
	endfunction : clamp_mv

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			uv_thresh <= UV_DEF_MV;
		end else if (clk_en) begin
			uv_thresh <= clamp_mv(uv_threshold_mv);
		end
	end

	assign uv_enter   = min_cell_mv < uv_thresh;
	assign uv_recover = min_cell_mv > UV_RECOVER_MV;

	// ------------------------------------------------------------
	// idle timer for standby entry
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idle_cnt <= '0;
		end else if (clk_en) begin
			if (load_active || power_state != BPM_ACTIVE) begin
				idle_cnt <= '0;
			end else if (!idle_done) begin
				idle_cnt <= idle_cnt + 48'h1;
			end
		end
	end

	assign idle_done = idle_cnt >= 48'(IDLE_TICKS - 1);

	// ------------------------------------------------------------
	// state transitions
	// ------------------------------------------------------------
	always_comb begin
		next_state = power_state;
		unique case (power_state)
			BPM_ACTIVE: begin
				if (ship_cmd && ship_cmd_auth) begin
					next_state = BPM_SHIP;
				end else if (fw_standby_en && idle_done) begin
					next_state = BPM_STANDBY;
				end
			end
			BPM_STANDBY: begin
				if (load_active) begin
					next_state = BPM_ACTIVE;
				end else if (ship_cmd && ship_cmd_auth) begin
					next_state = BPM_SHIP;
				end
			end
			BPM_SHIP: begin
				if (smb_active) begin
					next_state = BPM_ACTIVE;
				end
			end
			BPM_DEEP_UV: begin
				if (uv_recover) begin
					next_state = BPM_ACTIVE;
				end
			end
		endcase
		if (uv_enter && power_state != BPM_DEEP_UV) begin
			next_state = BPM_DEEP_UV;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			power_state <= BPM_ACTIVE;
		end else if (clk_en) begin
			power_state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// measurement tick per state
	// ------------------------------------------------------------
	always_comb begin
		unique case (power_state)
			BPM_ACTIVE:  tick_limit = 48'(ACTIVE_TICKS);
			BPM_STANDBY: tick_limit = 48'(STANDBY_TICKS);
			BPM_SHIP:    tick_limit = 48'(SHIP_TICKS);
			BPM_DEEP_UV: tick_limit = '0;
		endcase
	end

	assign tick = (power_state != BPM_DEEP_UV) && (tick_cnt >= tick_limit - 48'h1);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (clk_en) begin
			if (tick || next_state != power_state) begin
				tick_cnt <= '0;
			end else if (power_state != BPM_DEEP_UV) begin
				tick_cnt <= tick_cnt + 48'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// history store once per ship entry
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ship_logged <= 1'b0;
		end else if (clk_en) begin
			ship_logged <= (power_state == BPM_SHIP) && (ship_logged || tick);
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			switch_out <= '{chg_on: 1'b0, dsg_on: 1'b0, pre_on: 1'b0};
			status_out <= '0;
		end else if (clk_en) begin
			status_out.meas_tick <= tick;
			status_out.log_store <= (power_state == BPM_SHIP) && tick && !ship_logged;
			unique case (power_state)
				BPM_ACTIVE, BPM_STANDBY: begin
					switch_out            <= safety_switch;
					status_out.protect_en <= 1'b1;
					status_out.ocp_en     <= 1'b1;
					status_out.low_power  <= 1'b0;
				end
				BPM_SHIP: begin
					switch_out            <= '0;
					status_out.protect_en <= 1'b0;
					status_out.ocp_en     <= 1'b0;
					status_out.low_power  <= 1'b0;
				end
				BPM_DEEP_UV: begin
					switch_out.chg_on     <= 1'b0;
					switch_out.dsg_on     <= 1'b0;
					switch_out.pre_on     <= charger_present;
					status_out.protect_en <= 1'b0;
					status_out.ocp_en     <= 1'b0;
					status_out.low_power  <= 1'b1;
				end
			endcase
		end
	end

endmodule : bpm_power_mode

// >>> src/bpm_pkg.sv
// package: power-mode enums, carriers and timing constants
package bpm_pkg;

	// ------------------------------------------------------------
	// power states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BPM_ACTIVE,
		BPM_STANDBY,
		BPM_SHIP,
		BPM_DEEP_UV
	} bpm_state_t;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 125000000;
	localparam int unsigned ACTIVE_PERIOD_MS  = 1000;
	localparam int unsigned STANDBY_PERIOD_MS = 8000;
	localparam int unsigned SHIP_PERIOD_MS    = 16000;
	localparam int unsigned IDLE_TIME_MS      = 30000;
	localparam longint unsigned ACTIVE_TICK_CYC  = longint'(CLK_HZ) / 1000 * ACTIVE_PERIOD_MS;
	localparam longint unsigned STANDBY_TICK_CYC = longint'(CLK_HZ) / 1000 * STANDBY_PERIOD_MS;
	localparam longint unsigned SHIP_TICK_CYC    = longint'(CLK_HZ) / 1000 * SHIP_PERIOD_MS;
	localparam longint unsigned IDLE_CYC         = longint'(CLK_HZ) / 1000 * IDLE_TIME_MS;

	// ------------------------------------------------------------
	// cell voltage thresholds, millivolts
	// ------------------------------------------------------------
	localparam logic [15:0] UV_MIN_MV     = 16'h08FC; // 2300
	localparam logic [15:0] UV_MAX_MV     = 16'h0A8C; // 2700
	localparam logic [15:0] UV_DEF_MV     = 16'h09C4; // 2500
	localparam logic [15:0] UV_RECOVER_MV = 16'h0A8C; // 2700
	localparam int unsigned SYNC_STAGES   = 3;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic chg_on;
		logic dsg_on;
		logic pre_on;
	} bpm_switch_t;

	typedef struct packed {
		logic protect_en;
		logic ocp_en;
		logic meas_tick;
		logic log_store;
		logic low_power;
	} bpm_status_t;

endpackage : bpm_pkg

// >>> src/bpm_pin_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bpm_pin_sync #(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	// pins
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);
	import bpm_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ------------------------------------------------------------
	// shift chain; stage1 feeds only stage2
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else if (clk_en) begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// ------------------------------------------------------------
	// a bit changes once stage2 and stage3 agree
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					pin_sync[g] <= 1'b0;
				end else if (clk_en && (stage2[g] == stage3[g])) begin
					pin_sync[g] <= stage3[g];
				end
			end
		end
	endgenerate

endmodule : bpm_pin_sync

// >>> test/bpm_host_model.sv
// model: host side, bus lines and protected ship command
`timescale 1ns/10ps
module bpm_host_model (
	// clock
	input  wire logic clk_sys,
	// bench controls
	input  wire logic bus_on,
	input  wire logic ship_req,
	input  wire logic auth_req,
	// toward the device
	output logic      smb_clk_pin,
	output logic      smb_dat_pin,
	output logic      ship_cmd,
	output logic      ship_cmd_auth
);
	initial begin
		{smb_clk_pin, smb_dat_pin, ship_cmd, ship_cmd_auth} = 4'h0;
	end
	// lines held low while idle, clocking while active
	always @(posedge clk_sys) begin
		smb_clk_pin   <= bus_on & ~smb_clk_pin;
		smb_dat_pin   <= bus_on;
		ship_cmd      <= ship_req;
		ship_cmd_auth <= ship_req & auth_req;
	end
endmodule : bpm_host_model

// >>> test/bpm_power_mode_chk.sv
// checker: power-mode output relations
`timescale 1ns/10ps
module bpm_power_mode_chk
	import bpm_pkg::*;
#(
	parameter longint unsigned ACTIVE_TICKS = 10
) (
	// clock, reset, enable
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 clk_en,
	// commands and pins
	input wire logic                 fw_standby_en,
	input wire logic                 ship_cmd,
	input wire logic                 ship_cmd_auth,
	input wire logic                 smb_clk_pin,
	input wire logic                 smb_dat_pin,
	// measurements
	input wire logic                 load_active,
	input wire logic [15:0]          min_cell_mv,
	input wire logic [15:0]          uv_threshold_mv,
	input wire logic                 charger_present,
	input wire bpm_pkg::bpm_switch_t safety_switch,
	// outputs
	input wire bpm_pkg::bpm_state_t  power_state,
	input wire bpm_pkg::bpm_switch_t switch_out,
	input wire bpm_pkg::bpm_status_t status_out
);
	localparam int ACT_W = int'(ACTIVE_TICKS) + 2;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_active_tick: assert property (power_state == BPM_ACTIVE |-> ##[0:ACT_W]
		(status_out.meas_tick || power_state != BPM_ACTIVE)) else $error("no refresh tick");
	a_protect_on: assert property (power_state inside {BPM_ACTIVE, BPM_STANDBY} |=>
		status_out.protect_en && status_out.ocp_en) else $error("protection off");
	a_ship_open: assert property (power_state == BPM_SHIP |=> switch_out == 3'h0 &&
		!status_out.protect_en && !status_out.ocp_en) else $error("ship outputs");
	a_ship_cause: assert property ($rose(power_state == BPM_SHIP) |->
		$past(ship_cmd && ship_cmd_auth)) else $error("ship without command");
	a_ship_exit: assert property (power_state == BPM_SHIP && (smb_clk_pin || smb_dat_pin) |->
		##[1:6] power_state != BPM_SHIP) else $error("ship kept");
	a_uv_open: assert property (power_state == BPM_DEEP_UV |=> !switch_out.chg_on &&
		!switch_out.dsg_on && status_out.low_power && !status_out.protect_en) else $error("uv outputs");
	a_uv_pre: assert property (power_state == BPM_DEEP_UV && $stable(charger_present) |=>
		$changed(charger_present) || switch_out.pre_on == charger_present) else $error("precharge");
	a_uv_enter: assert property (min_cell_mv < UV_MIN_MV |=> power_state == BPM_DEEP_UV)
		else $error("uv entry missed");
	a_uv_hold: assert property (power_state == BPM_DEEP_UV && min_cell_mv <= UV_RECOVER_MV |=>
		power_state == BPM_DEEP_UV) else $error("uv left early");
	a_uv_exit: assert property (power_state == BPM_DEEP_UV && min_cell_mv > UV_RECOVER_MV |=>
		power_state == BPM_ACTIVE) else $error("uv exit missed");
	a_load_wake: assert property (power_state == BPM_STANDBY && load_active &&
		min_cell_mv > UV_MAX_MV |=> power_state == BPM_ACTIVE) else $error("no wake");
endmodule : bpm_power_mode_chk
bind bpm_power_mode bpm_power_mode_chk #(.ACTIVE_TICKS(ACTIVE_TICKS)) chk (.clk_sys(clk_sys),
	.rst_n(rst_n), .clk_en(clk_en), .fw_standby_en(fw_standby_en), .ship_cmd(ship_cmd),
	.ship_cmd_auth(ship_cmd_auth), .smb_clk_pin(smb_clk_pin), .smb_dat_pin(smb_dat_pin),
	.load_active(load_active), .min_cell_mv(min_cell_mv), .uv_threshold_mv(uv_threshold_mv),
	.charger_present(charger_present), .safety_switch(safety_switch), .power_state(power_state),
	.switch_out(switch_out), .status_out(status_out));

// >>> test/test_bpm_power_mode.sv
// testbench: power-mode sequencing against queued expectations
`timescale 1ns/10ps
module test_bpm_power_mode;
	import bpm_pkg::*;
	logic        clk_sys = 0, rst_n = 0, clk_en = 1, fw_standby_en = 0, load_active = 1, charger_present = 0;
	logic        bus_on = 0, ship_req = 0, auth_req = 0, smb_clk_pin, smb_dat_pin, ship_cmd, ship_cmd_auth;
	logic [15:0] min_cell_mv = 16'h0E10, uv_threshold_mv = UV_DEF_MV, thr;
	bpm_switch_t safety_switch = 3'h0, switch_out;
	bpm_status_t status_out;
	bpm_state_t  power_state, last_state = BPM_ACTIVE, exp_q[$];
	int          failures = 0, tests_run = 0, seed = 59, i, k;

	initial forever #4 clk_sys = ~clk_sys;
	bpm_power_mode #(.ACTIVE_TICKS(10), .STANDBY_TICKS(20), .SHIP_TICKS(40), .IDLE_TICKS(50)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .fw_standby_en(fw_standby_en),
		.ship_cmd(ship_cmd), .ship_cmd_auth(ship_cmd_auth), .smb_clk_pin(smb_clk_pin),
		.smb_dat_pin(smb_dat_pin), .load_active(load_active), .min_cell_mv(min_cell_mv),
		.uv_threshold_mv(uv_threshold_mv), .charger_present(charger_present),
		.safety_switch(safety_switch), .power_state(power_state), .switch_out(switch_out),
		.status_out(status_out));
	bpm_host_model host (.clk_sys(clk_sys), .bus_on(bus_on), .ship_req(ship_req), .auth_req(auth_req),
		.smb_clk_pin(smb_clk_pin), .smb_dat_pin(smb_dat_pin), .ship_cmd(ship_cmd),
		.ship_cmd_auth(ship_cmd_auth));

	task check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task settle;
		for (k = 0; k < 200 && exp_q.size() != 0; k++) step(1);
		check(exp_q.size() == 0, "state change missing");
	endtask : settle
	task ship_pulse(input logic auth);
		auth_req = auth;
		ship_req = 1;
		step(1);
		ship_req = 0;
	endtask : ship_pulse
	// watcher: each state change consumes the oldest note
	always @(negedge clk_sys) begin
		if (rst_n && power_state !== last_state) begin
			last_state = power_state;
			if (exp_q.size() == 0) check(1'b0, "unexpected state change");
			else check(power_state === exp_q.pop_front(), "wrong state");
		end
	end

	initial begin
		safety_switch = 3'($random(seed));
		step(20);
		rst_n = 1;
		step(2);
		check(power_state === BPM_ACTIVE && switch_out === safety_switch, "reset state");
		check(status_out.protect_en === 1'b1 && status_out.ocp_en === 1'b1, "active prot");
		clk_en = 0;
		min_cell_mv = 16'h0960;
		step(2);
		check(power_state === BPM_ACTIVE && status_out.protect_en === 1'b1, "frozen state moved");
		clk_en = 1;
		min_cell_mv = 16'h0E10;
		ship_pulse(1'b0);
		step(6);
		exp_q.push_back(BPM_SHIP);
		ship_pulse(1'b1);
		settle();
		step(1);
		check(switch_out === 3'h0 && status_out.protect_en === 1'b0, "ship outputs");
		for (k = 0; k < 60 && status_out.log_store !== 1'b1; k++) step(1);
		check(status_out.log_store === 1'b1, "no ship log");
		exp_q.push_back(BPM_ACTIVE);
		bus_on = 1;
		settle();
		bus_on = 0;
		load_active = 0;
		step(60);
		check(power_state === BPM_ACTIVE, "standby unasked");
		load_active = 1;
		step(1);
		exp_q.push_back(BPM_STANDBY);
		fw_standby_en = 1;
		load_active = 0;
		step(40);
		check(power_state === BPM_ACTIVE, "standby early");
		settle();
		check(status_out.ocp_en === 1'b1, "standby prot");
		exp_q.push_back(BPM_ACTIVE);
		load_active = 1;
		settle();
		for (i = 0; i < 3; i++) begin
			if (i == 1) begin
				exp_q.push_back(BPM_STANDBY);
				load_active = 0;
				settle();
			end
			thr = (i == 2) ? 16'hFFFF : UV_MIN_MV + 16'(($random(seed) & 32'hFFFF) % 401);
			uv_threshold_mv = thr;
			charger_present = 1'($random(seed));
			step(2);
			exp_q.push_back(BPM_DEEP_UV);
			min_cell_mv = ((i == 2) ? UV_MAX_MV : (i == 0) ? UV_MIN_MV : thr) - 16'h1
				- 16'(($random(seed) & 32'hFF) % 40);
			settle();
			load_active = 1;
			ship_pulse(1'b1);
			step(3);
			check(switch_out === {2'h0, charger_present} && status_out.low_power === 1'b1, "uv sw");
			min_cell_mv = UV_RECOVER_MV;
			step(5);
			exp_q.push_back(BPM_ACTIVE);
			min_cell_mv = UV_RECOVER_MV + 16'h1 + 16'(($random(seed) & 32'hFF) % 90);
			settle();
		end
		report_and_stop();
	end
	initial begin
		#100000;
		failures++;
		report_and_stop();
	end
	task report_and_stop;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
endmodule : test_bpm_power_mode
